// File: hdl/rft_frame_timing.sv
// Frame timing registers: delayed-transmission timer, pulse width override, silence timeout
//
// Summary of operation
// - Hold low eight bits of 14-bit transmit delay, 590 ns steps, 1..16383.
// - Delay length of zero disables the timer; transmission goes without delay.
// - Delay low byte clears at reset, chip enable low, and protocol write.
// - Delay high bits from high-byte bits 5..0; bits 7..6 pick start condition.
// - Zero pulse override gives the selected protocol's nominal pulse width.
// - Nonzero override makes the pulse last value times 73.7 ns.
// - Pulse override clears at reset, chip enable low, and protocol write.
// - Nominal widths: 9.44 us; 2.36 us, 1.4 us, 737 ns, 442 ns.
// - No reply within timeout after a slot raises interrupt and sets flag.
// - Timeout equals silence register value times 37.76 us.
// - Timeout counting starts at end of transmitted end-of-frame.
// - Timeout interrupt only while the vicinity protocol is active.
// - Silence register resets to 0x0E; protocol write presets 755/1812/529 us.
`default_nettype none
module rft_frame_timing #(
	parameter int unsigned SILENCE_STEP_CYC = rft_pkg::SILENCE_STEP_CYC
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	input  wire logic                   chip_en,
	input  wire rft_pkg::rft_reg_req_t  reg_req,
	output var  logic [7:0]             reg_rdata_r,
	input  wire rft_pkg::rft_frame_ev_t frame_ev,
	input  wire logic                   tx_req,
	output var  logic                   tx_go_r,
	input  wire logic                   mod_req,
	output var  logic                   mod_pulse_r,
	input  wire logic                   silence_flag_clr,
	output var  logic                   silence_irq_r,
	output var  logic                   silence_flag_r
);

	// ********************************************************
	// Chip enable synchroniser
	// ********************************************************
	logic en_meta_r;
	logic en_sync_r;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			en_meta_r <= 1'b0;
			en_sync_r <= 1'b0;
		end
		else
		begin
			en_meta_r <= chip_en;
			en_sync_r <= en_meta_r;
		end
	end

	// ********************************************************
	// Register file
	// ********************************************************
	logic [7:0] proto_sel_r,  proto_sel_nxt;
	logic [7:0] delay_high_r, delay_high_nxt;
	logic [7:0] delay_low_r,  delay_low_nxt;
	logic [7:0] pulse_ovr_r,  pulse_ovr_nxt;
	logic [7:0] silence_r,    silence_nxt;
	logic [7:0] rdata_nxt;
	logic       proto_wr;
	rft_pkg::rft_proto_t proto;

	assign proto    = rft_pkg::rft_proto_t'(proto_sel_r[rft_pkg::PROTO_FIELD_MSB:0]);
	assign proto_wr = reg_req.wr && (reg_req.addr == rft_pkg::OFS_PROTO_SEL);

	always_comb
	begin
		proto_sel_nxt  = proto_sel_r;
		delay_high_nxt = delay_high_r;
		delay_low_nxt  = delay_low_r;
		pulse_ovr_nxt  = pulse_ovr_r;
		silence_nxt    = silence_r;
		rdata_nxt      = reg_rdata_r;
		if (!en_sync_r)
		begin
			// Chip disabled holds every register at its reset value
			proto_sel_nxt  = rft_pkg::RST_PROTO_SEL;
			delay_high_nxt = rft_pkg::RST_DELAY_HIGH;
			delay_low_nxt  = rft_pkg::RST_DELAY_LOW;
			pulse_ovr_nxt  = rft_pkg::RST_PULSE_OVR;
			silence_nxt    = rft_pkg::RST_SILENCE;
		end
		else if (proto_wr)
		begin
			proto_sel_nxt  = reg_req.wdata;
			delay_high_nxt = rft_pkg::RST_DELAY_HIGH;
			delay_low_nxt  = rft_pkg::RST_DELAY_LOW;
			pulse_ovr_nxt  = rft_pkg::RST_PULSE_OVR;
			case (reg_req.wdata[rft_pkg::PROTO_FIELD_MSB:0])
				rft_pkg::PROTO_V_LOW:  silence_nxt = rft_pkg::PRE_SIL_LO_RATE;
				rft_pkg::PROTO_V_HIGH: silence_nxt = rft_pkg::PRE_SIL_HI_RATE;
				default:               silence_nxt = rft_pkg::PRE_SIL_OTHER;
			endcase
		end
		else if (reg_req.wr)
		begin
			case (reg_req.addr)
				rft_pkg::OFS_DELAY_HIGH: delay_high_nxt = reg_req.wdata;
				rft_pkg::OFS_DELAY_LOW:  delay_low_nxt  = reg_req.wdata;
				rft_pkg::OFS_PULSE_OVR:  pulse_ovr_nxt  = reg_req.wdata;
				rft_pkg::OFS_SILENCE:    silence_nxt    = reg_req.wdata;
				default:                 ;
			endcase
		end
		if (reg_req.rd)
		begin
			case (reg_req.addr)
				rft_pkg::OFS_PROTO_SEL:  rdata_nxt = proto_sel_r;
				rft_pkg::OFS_DELAY_HIGH: rdata_nxt = delay_high_r;
				rft_pkg::OFS_DELAY_LOW:  rdata_nxt = delay_low_r;
				rft_pkg::OFS_PULSE_OVR:  rdata_nxt = pulse_ovr_r;
				rft_pkg::OFS_SILENCE:    rdata_nxt = silence_r;
				default:                 rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			proto_sel_r  <= rft_pkg::RST_PROTO_SEL;
			delay_high_r <= rft_pkg::RST_DELAY_HIGH;
			delay_low_r  <= rft_pkg::RST_DELAY_LOW;
			pulse_ovr_r  <= rft_pkg::RST_PULSE_OVR;
			silence_r    <= rft_pkg::RST_SILENCE;
			reg_rdata_r  <= 8'h00;
		end
		else
		begin
			proto_sel_r  <= proto_sel_nxt;
			delay_high_r <= delay_high_nxt;
			delay_low_r  <= delay_low_nxt;
			pulse_ovr_r  <= pulse_ovr_nxt;
			silence_r    <= silence_nxt;
			reg_rdata_r  <= rdata_nxt;
		end
	end

	// ********************************************************
	// Delayed-transmission timer
	// ********************************************************
	rft_pkg::rft_dly_state_t dly_state_r, dly_state_nxt;
	logic [13:0] dly_steps_r, dly_steps_nxt;
	logic [6:0]  dly_cyc_r,   dly_cyc_nxt;
	logic        tx_go_nxt;
	logic [13:0] delay_len;
	logic        start_hit;

	assign delay_len = {delay_high_r[rft_pkg::DELAY_LEN_HI_MSB:0], delay_low_r};

	always_comb
	begin
		case (rft_pkg::rft_start_t'(delay_high_r[7:rft_pkg::START_SEL_LSB]))
			rft_pkg::START_TX_SOF_BEGIN: start_hit = frame_ev.tx_sof_begin;
			rft_pkg::START_TX_SOF_END:   start_hit = frame_ev.tx_sof_end;
			rft_pkg::START_RX_SOF_BEGIN: start_hit = frame_ev.rx_sof_begin;
			rft_pkg::START_RX_SOF_END:   start_hit = frame_ev.rx_sof_end;
			default:                     start_hit = 1'b0;
		endcase
	end

	always_comb
	begin
		dly_state_nxt = dly_state_r;
		dly_steps_nxt = dly_steps_r;
		dly_cyc_nxt   = dly_cyc_r;
		tx_go_nxt     = 1'b0;
		case (dly_state_r)
			rft_pkg::DLY_IDLE:
				if (tx_req)
				begin
					if (delay_len == 14'h0000)
						tx_go_nxt = 1'b1;
					else
						dly_state_nxt = rft_pkg::DLY_ARMED;
				end
			rft_pkg::DLY_ARMED:
				if (start_hit)
				begin
					dly_state_nxt = rft_pkg::DLY_COUNT;
					dly_steps_nxt = delay_len;
					dly_cyc_nxt   = 7'h00;
				end
			rft_pkg::DLY_COUNT:
				if (dly_cyc_r == 7'(rft_pkg::DELAY_STEP_CYC - 1))
				begin
					dly_cyc_nxt   = 7'h00;
					dly_steps_nxt = dly_steps_r - 14'h0001;
					if (dly_steps_r == 14'h0001)
					begin
						tx_go_nxt     = 1'b1;
						dly_state_nxt = rft_pkg::DLY_IDLE;
					end
				end
				else
					dly_cyc_nxt = dly_cyc_r + 7'h01;
			default: dly_state_nxt = rft_pkg::DLY_IDLE;
		endcase
		// A protocol change or disable abandons any pending delayed start except one whose last step ends in that cycle
		if (!en_sync_r || proto_wr)
			dly_state_nxt = rft_pkg::DLY_IDLE;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dly_state_r <= rft_pkg::DLY_IDLE;
			dly_steps_r <= 14'h0000;
			dly_cyc_r   <= 7'h00;
			tx_go_r     <= 1'b0;
		end
		else
		begin
			dly_state_r <= dly_state_nxt;
			dly_steps_r <= dly_steps_nxt;
			dly_cyc_r   <= dly_cyc_nxt;
			tx_go_r     <= tx_go_nxt;
		end
	end

	// ********************************************************
	// Modulation pulse width
	// ********************************************************
	logic [17:0] pulse_tns_r, pulse_tns_nxt;
	logic [17:0] pulse_width;
	logic        mod_pulse_nxt;

	always_comb
	begin
		if (pulse_ovr_r != 8'h00)
			pulse_width = 18'(pulse_ovr_r) * rft_pkg::PULSE_STEP_TNS;
		else
		begin
			case (proto)
				rft_pkg::PROTO_A106: pulse_width = rft_pkg::NOM_A106_TNS;
				rft_pkg::PROTO_A212: pulse_width = rft_pkg::NOM_A212_TNS;
				rft_pkg::PROTO_A424: pulse_width = rft_pkg::NOM_A424_TNS;
				rft_pkg::PROTO_A848: pulse_width = rft_pkg::NOM_A848_TNS;
				default:             pulse_width = rft_pkg::NOM_15693_TNS;
			endcase
		end
	end

	always_comb
	begin
		mod_pulse_nxt = mod_pulse_r;
		pulse_tns_nxt = pulse_tns_r;
		if (!mod_pulse_r)
		begin
			if (mod_req)
			begin
				mod_pulse_nxt = 1'b1;
				pulse_tns_nxt = rft_pkg::CLK_PERIOD_TNS;
			end
		end
		else if (pulse_tns_r >= pulse_width)
			mod_pulse_nxt = 1'b0;
		else
			pulse_tns_nxt = pulse_tns_r + rft_pkg::CLK_PERIOD_TNS;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mod_pulse_r <= 1'b0;
			pulse_tns_r <= 18'h00000;
		end
		else
		begin
			mod_pulse_r <= mod_pulse_nxt;
			pulse_tns_r <= pulse_tns_nxt;
		end
	end

	// ********************************************************
	// No-response timeout
	// ********************************************************
	logic        sil_run_r,   sil_run_nxt;
	logic [7:0]  sil_steps_r, sil_steps_nxt;
	logic [11:0] sil_cyc_r,   sil_cyc_nxt;
	logic        silence_irq_nxt;
	logic        silence_flag_nxt;
	logic        sil_expire;
	logic        vicinity;

	assign vicinity   = (proto == rft_pkg::PROTO_V_LOW) || (proto == rft_pkg::PROTO_V_HIGH);
	assign sil_expire = sil_run_r && (sil_steps_r == 8'h01) &&
		(sil_cyc_r == 12'(SILENCE_STEP_CYC - 1));

	always_comb
	begin
		sil_run_nxt      = sil_run_r;
		sil_steps_nxt    = sil_steps_r;
		sil_cyc_nxt      = sil_cyc_r;
		silence_irq_nxt  = 1'b0;
		silence_flag_nxt = silence_flag_r;
		if (frame_ev.tx_eof_end && vicinity && (silence_r != 8'h00))
		begin
			sil_run_nxt   = 1'b1;
			sil_steps_nxt = silence_r;
			sil_cyc_nxt   = 12'h000;
		end
		else if (frame_ev.rx_sof_begin || !vicinity)
			sil_run_nxt = 1'b0;
		else if (sil_run_r)
		begin
			if (sil_cyc_r == 12'(SILENCE_STEP_CYC - 1))
			begin
				sil_cyc_nxt   = 12'h000;
				sil_steps_nxt = sil_steps_r - 8'h01;
				if (sil_expire)
					sil_run_nxt = 1'b0;
			end
			else
				sil_cyc_nxt = sil_cyc_r + 12'h001;
		end
		if (silence_flag_clr)
			silence_flag_nxt = 1'b0;
		// Set wins over a clear in the same cycle so no timeout is lost
		if (sil_expire && vicinity && !frame_ev.rx_sof_begin)
		begin
			silence_irq_nxt  = 1'b1;
			silence_flag_nxt = 1'b1;
		end
		if (!en_sync_r)
		begin
			sil_run_nxt      = 1'b0;
			silence_irq_nxt  = 1'b0;
			silence_flag_nxt = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sil_run_r      <= 1'b0;
			sil_steps_r    <= 8'h00;
			sil_cyc_r      <= 12'h000;
			silence_irq_r  <= 1'b0;
			silence_flag_r <= 1'b0;
		end
		else
		begin
			sil_run_r      <= sil_run_nxt;
			sil_steps_r    <= sil_steps_nxt;
			sil_cyc_r      <= sil_cyc_nxt;
			silence_irq_r  <= silence_irq_nxt;
			silence_flag_r <= silence_flag_nxt;
		end
	end

	// ********************************************************
	// Assertions
	// ********************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// High time is counted here rather than unrolled as a long repetition
	logic [10:0] chk_hi_cnt_r, chk_hi_cnt_nxt;
	logic        chk_a106_r,   chk_a106_nxt;

	always_comb
	begin
		chk_hi_cnt_nxt = 11'h000;
		if (mod_pulse_r)
			chk_hi_cnt_nxt = chk_hi_cnt_r + 11'h001;
		// A register write during the pulse may change its width, so that pulse is not judged
		chk_a106_nxt = chk_a106_r && mod_pulse_r && !reg_req.wr;
		if (!mod_pulse_r && mod_req && (pulse_ovr_r == 8'h00)
			&& (proto == rft_pkg::PROTO_A106) && !reg_req.wr)
			chk_a106_nxt = 1'b1;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			chk_hi_cnt_r <= 11'h000;
			chk_a106_r   <= 1'b0;
		end
		else
		begin
			chk_hi_cnt_r <= chk_hi_cnt_nxt;
			chk_a106_r   <= chk_a106_nxt;
		end
	end

	delay_low_clear_a: assert property (
		(proto_wr && en_sync_r) |=> (delay_low_r == 8'h00))
		else $error("delay low byte not cleared by protocol write");
	pulse_ovr_clear_a: assert property (
		!en_sync_r |=> (pulse_ovr_r == 8'h00))
		else $error("pulse override not cleared while disabled");
	silence_preset_a: assert property (
		(proto_wr && en_sync_r && reg_req.wdata[2:0] == 3'b001) |=> (silence_r == 8'h14))
		else $error("silence preset for high rate wrong");
	zero_delay_go_a: assert property (
		(en_sync_r && !proto_wr && dly_state_r == rft_pkg::DLY_IDLE && tx_req
			&& delay_len == 14'h0000) |=> tx_go_r)
		else $error("zero delay did not start at once");
	delay_count_a: assert property (
		(dly_state_r == rft_pkg::DLY_COUNT && dly_cyc_r == 7'h3A && dly_steps_r == 14'h0001
			&& en_sync_r && !proto_wr) |=> tx_go_r && dly_state_r == rft_pkg::DLY_IDLE)
		else $error("delay timer missed its end");
	step_wrap_a: assert property (
		(dly_state_r == rft_pkg::DLY_COUNT) |-> (dly_cyc_r <= 7'h3A))
		else $error("delay step exceeds 59 cycles");
	pulse_a106_a: assert property (
		(chk_a106_r && !mod_pulse_r) |-> (chk_hi_cnt_r == 11'h0EC))
		else $error("nominal 106 kbps pulse width wrong");
	pulse_ovr_one_a: assert property (
		(!mod_pulse_r && mod_req && pulse_ovr_r == 8'h01 && !reg_req.wr)
			|=> mod_pulse_r [*8] ##1 !mod_pulse_r)
		else $error("one-step override pulse wrong");
	irq_vicinity_a: assert property (
		silence_irq_r |-> $past(vicinity))
		else $error("timeout interrupt outside vicinity protocol");
	flag_follows_a: assert property (
		silence_irq_r |-> silence_flag_r)
		else $error("interrupt without no-response flag");
	eof_starts_a: assert property (
		(frame_ev.tx_eof_end && vicinity && silence_r != 8'h00 && en_sync_r)
			|=> sil_run_r && sil_cyc_r == 12'h000)
		else $error("timeout not started at end of frame");

	delayed_tx_c: cover property (dly_state_r == rft_pkg::DLY_COUNT ##[1:1000] tx_go_r);
	override_pulse_c: cover property (pulse_ovr_r != 8'h00 && mod_pulse_r);
	silence_irq_c: cover property (silence_irq_r);
	reply_cancel_c: cover property (sil_run_r && frame_ev.rx_sof_begin);

endmodule : rft_frame_timing
`default_nettype wire

// File: shared/rft_pkg.sv
// Package for the frame timing register block: offsets, presets, timing constants, types
`default_nettype none
package rft_pkg;

	// ********************************************************
	// Register offsets
	// ********************************************************
	localparam logic [4:0] OFS_PROTO_SEL   = 5'h01;
	localparam logic [4:0] OFS_DELAY_HIGH  = 5'h04;
	localparam logic [4:0] OFS_DELAY_LOW   = 5'h05;
	localparam logic [4:0] OFS_PULSE_OVR   = 5'h06;
	localparam logic [4:0] OFS_SILENCE     = 5'h07;

	// ********************************************************
	// Reset and preset values
	// ********************************************************
	localparam logic [7:0] RST_PROTO_SEL   = 8'h00;
	localparam logic [7:0] RST_DELAY_HIGH  = 8'hC2;
	localparam logic [7:0] RST_DELAY_LOW   = 8'h00;
	localparam logic [7:0] RST_PULSE_OVR   = 8'h00;
	localparam logic [7:0] RST_SILENCE     = 8'h0E;
	localparam logic [7:0] PRE_SIL_HI_RATE = 8'h14;
	localparam logic [7:0] PRE_SIL_LO_RATE = 8'h30;
	localparam logic [7:0] PRE_SIL_OTHER   = 8'h0E;

	// ********************************************************
	// Field positions
	// ********************************************************
	localparam int DELAY_LEN_HI_MSB = 5;
	localparam int START_SEL_LSB    = 6;
	localparam int PROTO_FIELD_MSB  = 2;

	// ********************************************************
	// Timing: times as printed, cycle counts derived
	// ********************************************************
	localparam int CLK_PERIOD_NS     = 10;
	localparam int DELAY_STEP_NS     = 590;
	localparam int DELAY_STEP_CYC    = (DELAY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SILENCE_STEP_NS   = 37760;
	localparam int SILENCE_STEP_CYC  = (SILENCE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Pulse widths are kept in tenths of a nanosecond so 73.7 ns steps stay exact
	localparam logic [17:0] CLK_PERIOD_TNS = 18'd100;
	localparam logic [17:0] PULSE_STEP_TNS = 18'd737;
	localparam logic [17:0] NOM_15693_TNS  = 18'd94400;
	localparam logic [17:0] NOM_A106_TNS   = 18'd23600;
	localparam logic [17:0] NOM_A212_TNS   = 18'd14000;
	localparam logic [17:0] NOM_A424_TNS   = 18'd7370;
	localparam logic [17:0] NOM_A848_TNS   = 18'd4420;

	// ********************************************************
	// Types
	// ********************************************************
	typedef enum logic [2:0] {
		PROTO_V_LOW  = 3'b000,
		PROTO_V_HIGH = 3'b001,
		PROTO_A106   = 3'b010,
		PROTO_A212   = 3'b011,
		PROTO_A424   = 3'b100,
		PROTO_A848   = 3'b101,
		PROTO_OTH6   = 3'b110,
		PROTO_OTH7   = 3'b111
	} rft_proto_t;

	typedef enum logic [1:0] {
		START_TX_SOF_BEGIN = 2'b00,
		START_TX_SOF_END   = 2'b01,
		START_RX_SOF_BEGIN = 2'b10,
		START_RX_SOF_END   = 2'b11
	} rft_start_t;

	typedef enum logic [1:0] {
		DLY_IDLE  = 2'b00,
		DLY_ARMED = 2'b01,
		DLY_COUNT = 2'b10
	} rft_dly_state_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [4:0] addr;
		logic [7:0] wdata;
	} rft_reg_req_t;

	typedef struct packed {
		logic tx_sof_begin;
		logic tx_sof_end;
		logic rx_sof_begin;
		logic rx_sof_end;
		logic tx_eof_end;
	} rft_frame_ev_t;

endpackage : rft_pkg
`default_nettype wire

// File: test/rft_host_model.sv
// Host controller model that programs the timing registers over the strobe port
`default_nettype none
module rft_host_model (
	input  wire logic                  core_clk,
	output var  rft_pkg::rft_reg_req_t reg_req,
	input  wire logic [7:0]            reg_rdata_r
);
	timeunit 1ns;
	timeprecision 1ps;

	initial reg_req = '0;

	// ********************************************************
	// Bus cycles
	// ********************************************************
	// Idle address and data show the inverse of the last value so stale
	// values are never mistaken for a held request
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_req = {1'b1, 1'b0, a, d};
		@(negedge core_clk);
		reg_req = {2'b00, ~a, ~d};
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(negedge core_clk);
		reg_req = {1'b0, 1'b1, a, 8'h00};
		@(negedge core_clk);
		reg_req = {2'b00, ~a, 8'hFF};
		@(negedge core_clk);
		d = reg_rdata_r;
	endtask : rd
endmodule : rft_host_model
`default_nettype wire

// File: test/tb_rft_frame_timing.sv
// Self-checking testbench for the frame timing register block
`default_nettype none
module tb_rft_frame_timing;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int SIL_STEP = 4;

	logic                   core_clk;
	logic                   rst_n;
	logic                   chip_en;
	rft_pkg::rft_reg_req_t  reg_req;
	logic [7:0]             reg_rdata_r;
	rft_pkg::rft_frame_ev_t frame_ev;
	logic                   tx_req;
	logic                   tx_go_r;
	logic                   mod_req;
	logic                   mod_pulse_r;
	logic                   silence_flag_clr;
	logic                   silence_irq_r;
	logic                   silence_flag_r;
	int                     n_mismatch;
	int                     cmp_count;
	logic [7:0]             lfsr_r;
	logic [7:0]             rd_val;
	logic [7:0]             v;
	int                     n;

	rft_frame_timing #(
		.SILENCE_STEP_CYC (SIL_STEP)
	) u_dut (
		.core_clk         (core_clk),
		.rst_n            (rst_n),
		.chip_en          (chip_en),
		.reg_req          (reg_req),
		.reg_rdata_r      (reg_rdata_r),
		.frame_ev         (frame_ev),
		.tx_req           (tx_req),
		.tx_go_r          (tx_go_r),
		.mod_req          (mod_req),
		.mod_pulse_r      (mod_pulse_r),
		.silence_flag_clr (silence_flag_clr),
		.silence_irq_r    (silence_irq_r),
		.silence_flag_r   (silence_flag_r)
	);

	rft_host_model u_host (
		.core_clk    (core_clk),
		.reg_req     (reg_req),
		.reg_rdata_r (reg_rdata_r)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// ********************************************************
	// Expectations and helpers
	// ********************************************************
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr_next

	// Nominal widths rounded up to whole 10 ns cycles
	function automatic int nom_cyc(input logic [2:0] p);
		case (p)
			3'h2: return 236;
			3'h3: return 140;
			3'h4: return 74;
			3'h5: return 45;
			default: return 944;
		endcase
	endfunction : nom_cyc

	// 1812 us and 755 us over 37.76 us steps; 529 us for the rest
	function automatic logic [7:0] sil_preset(input logic [2:0] p);
		case (p)
			3'h0: return 8'h30;
			3'h1: return 8'h14;
			default: return 8'h0E;
		endcase
	endfunction : sil_preset

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
		u_host.rd(a, rd_val);
		chk({8'h00, rd_val}, {8'h00, exp});
	endtask : rd_chk

	task automatic step_rnd();
		lfsr_r = lfsr_next(lfsr_r);
		v = lfsr_r;
	endtask : step_rnd

	task automatic ev(input logic [4:0] e);
		@(negedge core_clk);
		frame_ev = rft_pkg::rft_frame_ev_t'(e);
		@(negedge core_clk);
		frame_ev = '0;
	endtask : ev

	// Counts cycles until tx_go_r (which 0) or silence_irq_r (which 1) rises
	task automatic wait_hi(input int which, output int k);
		k = 0;
		while (k < 20000)
		begin
			@(negedge core_clk);
			k++;
			if ((which == 1 ? silence_irq_r : tx_go_r) === 1'b1)
				break;
		end
	endtask : wait_hi

	task automatic pulse_len(output int len);
		@(negedge core_clk);
		mod_req = 1'b1;
		@(negedge core_clk);
		mod_req = 1'b0;
		len = 0;
		for (int i = 0; i < 3 && mod_pulse_r !== 1'b1; i++)
			@(negedge core_clk);
		while (mod_pulse_r === 1'b1 && len < 3000)
		begin
			len++;
			@(negedge core_clk);
		end
	endtask : pulse_len

	task automatic print_verdict();
		$display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict

	// ********************************************************
	// Watchdog
	// ********************************************************
	// Worst case run is well under 60k cycles
	initial
	begin
		#1000000;
		n_mismatch++;
		print_verdict();
	end

	// ********************************************************
	// Main sequence
	// ********************************************************
	initial
	begin
		rst_n = 1'b0;
		chip_en = 1'b1;
		frame_ev = '0;
		tx_req = 1'b0;
		mod_req = 1'b0;
		silence_flag_clr = 1'b0;
		n_mismatch = 0;
		cmp_count = 0;
		lfsr_r = 8'h31;
		repeat (4) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge core_clk);
		rd_chk(5'h05, 8'h00);
		rd_chk(5'h06, 8'h00);
		rd_chk(5'h07, 8'h0E);
		rd_chk(5'h04, 8'hC2);
		rd_chk(5'h1F, 8'h00);

		// Every protocol code: override, presets, nominal width
		for (int p = 0; p < 8; p++)
		begin
			step_rnd();
			u_host.wr(5'h05, v);
			rd_chk(5'h05, v);
			step_rnd();
			v = v | 8'h01;
			u_host.wr(5'h06, v);
			pulse_len(n);
			chk(n[15:0], 16'((v * 737 + 99) / 100));
			u_host.wr(5'h07, v);
			rd_chk(5'h07, v);
			step_rnd();
			v = {v[7:3], p[2:0]};
			u_host.wr(5'h01, v);
			rd_chk(5'h01, v);
			rd_chk(5'h05, 8'h00);
			rd_chk(5'h06, 8'h00);
			rd_chk(5'h07, sil_preset(p[2:0]));
			rd_chk(5'h04, 8'hC2);
			pulse_len(n);
			chk(n[15:0], 16'(nom_cyc(p[2:0])));
		end

		// Delay timer on each start condition; a wrong event comes first
		for (int s = 0; s < 4; s++)
		begin
			step_rnd();
			u_host.wr(5'h04, {s[1:0], 5'h00, (s == 3)});
			u_host.wr(5'h05, {6'h00, v[1:0]} + 8'h01);
			@(negedge core_clk);
			tx_req = 1'b1;
			@(negedge core_clk);
			tx_req = 1'b0;
			repeat (3) @(negedge core_clk);
			ev(5'h10 >> ((s + 1) % 4));
			ev(5'h10 >> s);
			wait_hi(0, n);
			chk(n[15:0], 16'(59 * ((s == 3 ? 256 : 0) + v[1:0] + 1)));
			@(negedge core_clk);
			chk({15'h0, tx_go_r}, 16'h0);
		end
		u_host.wr(5'h05, 8'h00);
		u_host.wr(5'h04, 8'h40);
		@(negedge core_clk);
		tx_req = 1'b1;
		@(negedge core_clk);
		chk({15'h0, tx_go_r}, 16'h1);
		tx_req = 1'b0;
		@(negedge core_clk);
		chk({15'h0, tx_go_r}, 16'h0);

		// Silence timeout after end of frame, then cancel cases
		u_host.wr(5'h01, 8'h00);
		step_rnd();
		v = {5'h00, v[2:0]} | 8'h01;
		u_host.wr(5'h07, v);
		ev(5'h01);
		wait_hi(1, n);
		chk(n[15:0], 16'(v * SIL_STEP));
		chk({15'h0, silence_flag_r}, 16'h1);
		@(negedge core_clk);
		chk({15'h0, silence_irq_r}, 16'h0);
		silence_flag_clr = 1'b1;
		@(negedge core_clk);
		silence_flag_clr = 1'b0;
		@(negedge core_clk);
		chk({15'h0, silence_flag_r}, 16'h0);
		ev(5'h01);
		ev(5'h04);
		repeat (60) @(negedge core_clk);
		chk({15'h0, silence_flag_r}, 16'h0);
		u_host.wr(5'h01, 8'h02);
		u_host.wr(5'h07, v);
		ev(5'h01);
		repeat (60) @(negedge core_clk);
		chk({15'h0, silence_flag_r}, 16'h0);

		// Chip enable low restores the reset values
		u_host.wr(5'h05, 8'h5A);
		u_host.wr(5'h06, 8'hA5);
		u_host.wr(5'h07, 8'h33);
		chip_en = 1'b0;
		repeat (4) @(negedge core_clk);
		chip_en = 1'b1;
		repeat (3) @(negedge core_clk);
		rd_chk(5'h05, 8'h00);
		rd_chk(5'h06, 8'h00);
		rd_chk(5'h07, 8'h0E);
		print_verdict();
	end
endmodule : tb_rft_frame_timing
`default_nettype wire
